/* inc/load_current_protection_monitor_regs.svh */
`ifndef LOAD_CURRENT_PROTECTION_MONITOR_REGS_SVH
`define LOAD_CURRENT_PROTECTION_MONITOR_REGS_SVH

// register byte offsets
`define CFG_OFS 8'h00
`define UC_OFS 8'h04
`define OT_OFS 8'h08
`define OVL_OFS 8'h0C
`define STAT_OFS 8'h10
`define IRQ_STAT_OFS 8'h14
`define IRQ_MASK_OFS 8'h18
`define CTRL_OFS 8'h1C

// field positions
`define RESP_BIT 0
`define OVSEL_LSB 4
`define OVMODE_LSB 8
`define UC_THR_LSB 0
`define UC_HYST_LSB 8
`define UC_TIME_LSB 16
`define OT_LVL_LSB 0
`define OT_HYST_LSB 8
`define OT_TIME_LSB 16
`define OVL_LVL_LSB 0
`define CLR_TRIP_BIT 0

// reset values and limits
`define RESP_RST 1'h0
`define OVSEL_RST 3'h0
`define OVSEL_MAX 8'h05
`define OVMODE_RST 2'h2
`define UC_THR_RST 7'h00
`define UC_THR_MAX 8'h64
`define UC_HYST_RST 5'h0A
`define UC_HYST_MIN 8'h01
`define UC_HYST_MAX 8'h14
`define UC_TIME_RST 8'h00
`define OT_LVL_RST 8'h82
`define OT_LVL_MAX 8'hFA
`define OT_HYST_RST 7'h0A
`define OT_HYST_MAX 8'h64
`define OT_TIME_RST 7'h05
`define OT_TIME_MAX 8'h64
`define OVL_LVL_RST 8'h82
`define OVL_LVL_MIN 8'h64
`define OVL_LVL_MAX 8'h96

// scaling of percent settings to 0.1 % measurement units
`define NEAR_SCALE 4'h7
`define FULL_SCALE 4'hA

// timing
`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 1000000
`define MS_PER_S 18'h0_03E8
`define MS_PER_DS 10'h064

`endif

/* inc/load_current_protection_monitor_pkg.sv */
package load_current_protection_monitor_pkg;

  typedef enum logic [1:0] {
    OV_AVOID,
    OV_OFF,
    OV_EXCITE_LEVEL,
    OV_EXCITE_DECEL
  } ov_mode_t;

  typedef enum logic [1:0] {
    FAULT_NONE,
    FAULT_UNDERCURRENT,
    FAULT_OVERTORQUE
  } fault_t;

endpackage : load_current_protection_monitor_pkg

/* hdl/load_current_protection_monitor.sv */
// Behaviour
// [R1] small-current response: 0 alarm, 1 trip
// [R2] alarm mode raises alarm, never trips
// [R3] trip mode trips after timed undercurrent
// [R4] undercurrent threshold 0 to 100 percent
// [R5] undercurrent hysteresis 1 to 20, default 10
// [R6] undercurrent time 0 to 255 s
// [R7] six selections: torque 0-2, output 3-5
// [R8] selections 0,1,3,4: alarm at 70 percent
// [R9] selections 2,5: alarm at 100 percent
// [R10] timed output after level held for time
// [R11] alarm selections never fault nor stop
// [R12] selections 1,4 trip after held level
// [R13] over-torque level 0 to 250, default 130
// [R14] over-torque hysteresis 0 to 100, default 10
// [R15] over-torque time 0.0 to 10.0 s
// [R16] overvoltage mode 0-3, mode 0 avoids
// [R17] mode 1 off, 2 level, 3 deceleration
// [R18] overvoltage level 100 to 150 percent
// [R19] timers restart when hysteresis clears condition
`timescale 1ns/1ps
`include "load_current_protection_monitor_regs.svh"

module load_current_protection_monitor #(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // measurements in 0.1 % of rated value
  input wire logic [11:0] torque_current,
  input wire logic [11:0] output_current,
  input wire logic [11:0] bus_voltage,
  input wire logic decelerating,
  // terminal and drive outputs
  output logic uc_alarm,
  output logic ot_alarm,
  output logic ot_timed,
  output logic trip,
  output logic stop_req,
  output load_current_protection_monitor_pkg::fault_t fault_code,
  output logic ov_extend_decel,
  output logic ov_overexcite,
  // interrupt
  output logic irq
);

  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  function automatic logic [12:0] scale(input logic [7:0] pct, input logic [3:0] k);
    scale = 13'(pct) * 13'(k);
  endfunction : scale

  function automatic logic [12:0] sat_sub(input logic [12:0] a, input logic [12:0] b);
    sat_sub = (a > b) ? a - b : 13'h0_000;
  endfunction : sat_sub

  // settings
  logic resp_reg;
  logic [2:0] ovsel_reg;
  load_current_protection_monitor_pkg::ov_mode_t ov_mode_reg;
  logic [6:0] uc_thr_reg;
  logic [4:0] uc_hyst_reg;
  logic [7:0] uc_time_reg;
  logic [7:0] ot_lvl_reg;
  logic [6:0] ot_hyst_reg;
  logic [6:0] ot_time_reg;
  logic [7:0] ovl_lvl_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;

  logic wr_cfg, wr_uc, wr_ot, wr_ovl, wr_istat, wr_imask, wr_ctrl;
  assign wr_cfg = wr_en && (addr == `CFG_OFS);
  assign wr_uc = wr_en && (addr == `UC_OFS);
  assign wr_ot = wr_en && (addr == `OT_OFS);
  assign wr_ovl = wr_en && (addr == `OVL_OFS);
  assign wr_istat = wr_en && (addr == `IRQ_STAT_OFS);
  assign wr_imask = wr_en && (addr == `IRQ_MASK_OFS);
  assign wr_ctrl = wr_en && (addr == `CTRL_OFS);

  // out-of-range writes saturate to the nearest legal setting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_reg <= `RESP_RST;
      ovsel_reg <= `OVSEL_RST;
      ov_mode_reg <= load_current_protection_monitor_pkg::ov_mode_t'(`OVMODE_RST);
    end else if (wr_cfg) begin
      resp_reg <= wdata[`RESP_BIT]; // [R1]
      ovsel_reg <= 3'(clamp({5'h00, wdata[`OVSEL_LSB +: 3]}, 8'h00, `OVSEL_MAX)); // [R7]
      ov_mode_reg <= load_current_protection_monitor_pkg::ov_mode_t'(wdata[`OVMODE_LSB +: 2]); // [R16]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uc_thr_reg <= `UC_THR_RST;
      uc_hyst_reg <= `UC_HYST_RST;
      uc_time_reg <= `UC_TIME_RST;
    end else if (wr_uc) begin
      uc_thr_reg <= 7'(clamp(wdata[`UC_THR_LSB +: 8], 8'h00, `UC_THR_MAX)); // [R4]
      uc_hyst_reg <= 5'(clamp(wdata[`UC_HYST_LSB +: 8], `UC_HYST_MIN, `UC_HYST_MAX)); // [R5]
      uc_time_reg <= wdata[`UC_TIME_LSB +: 8]; // [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ot_lvl_reg <= `OT_LVL_RST;
      ot_hyst_reg <= `OT_HYST_RST;
      ot_time_reg <= `OT_TIME_RST;
    end else if (wr_ot) begin
      ot_lvl_reg <= clamp(wdata[`OT_LVL_LSB +: 8], 8'h00, `OT_LVL_MAX); // [R13]
      ot_hyst_reg <= 7'(clamp(wdata[`OT_HYST_LSB +: 8], 8'h00, `OT_HYST_MAX)); // [R14]
      ot_time_reg <= 7'(clamp(wdata[`OT_TIME_LSB +: 8], 8'h00, `OT_TIME_MAX)); // [R15]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovl_lvl_reg <= `OVL_LVL_RST;
    end else if (wr_ovl) begin
      ovl_lvl_reg <= clamp(wdata[`OVL_LVL_LSB +: 8], `OVL_LVL_MIN, `OVL_LVL_MAX); // [R18]
    end
  end

  // 1 ms time base
  logic [15:0] div_reg;
  logic tick;
  assign tick = (div_reg == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || tick) begin
      div_reg <= 16'h0_000;
    end else begin
      div_reg <= div_reg + 16'h0_001;
    end
  end

  // undercurrent watch on output current
  logic uc_cond_reg;
  logic [17:0] uc_ms_reg, uc_limit;
  logic [12:0] uc_on, uc_off;
  logic uc_done;
  assign uc_on = scale({1'b0, uc_thr_reg}, `FULL_SCALE);
  assign uc_off = uc_on + scale({3'h0, uc_hyst_reg}, `FULL_SCALE); // [R5]
  assign uc_limit = 18'(uc_time_reg * `MS_PER_S); // [R6]
  assign uc_done = uc_cond_reg && (uc_ms_reg >= uc_limit);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uc_cond_reg <= 1'b0;
    end else if (!uc_cond_reg && ({1'b0, output_current} < uc_on)) begin
      uc_cond_reg <= 1'b1;
    end else if (uc_cond_reg && ({1'b0, output_current} >= uc_off)) begin
      uc_cond_reg <= 1'b0; // [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !uc_cond_reg) begin
      uc_ms_reg <= 18'h0_0000; // [R19]
    end else if (tick && (uc_ms_reg < uc_limit)) begin
      uc_ms_reg <= uc_ms_reg + 18'h0_0001;
    end
  end

  // over-torque / over-current watch
  logic torque_sel, near70_sel, fault_sel;
  logic [11:0] ot_cur;
  logic [12:0] near_on, near_off, full_on, full_off, ot_hyst10;
  assign torque_sel = (ovsel_reg < 3'h3); // [R7]
  assign near70_sel = (ovsel_reg != 3'h2) && (ovsel_reg != 3'h5);
  assign fault_sel = (ovsel_reg == 3'h1) || (ovsel_reg == 3'h4); // [R11]
  assign ot_cur = torque_sel ? torque_current : output_current;
  assign ot_hyst10 = scale({1'b0, ot_hyst_reg}, `FULL_SCALE); // [R14]
  assign full_on = scale(ot_lvl_reg, `FULL_SCALE);
  assign full_off = sat_sub(full_on, ot_hyst10);
  assign near_on = near70_sel ? scale(ot_lvl_reg, `NEAR_SCALE) : full_on; // [R8] [R9]
  assign near_off = sat_sub(near_on, ot_hyst10);

  logic near_reg, full_reg;
  logic [13:0] ot_ms_reg, ot_limit;
  logic ot_done;
  // 10.0 s is 10000 ticks, so the counter needs 14 bits
  assign ot_limit = 14'(ot_time_reg) * 14'(`MS_PER_DS); // [R15]
  assign ot_done = full_reg && (ot_ms_reg >= ot_limit); // [R10]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      near_reg <= 1'b0;
    end else if (!near_reg && ({1'b0, ot_cur} >= near_on)) begin
      near_reg <= 1'b1; // [R8] [R9]
    end else if (near_reg && ({1'b0, ot_cur} < near_off)) begin
      near_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      full_reg <= 1'b0;
    end else if (!full_reg && ({1'b0, ot_cur} >= full_on)) begin
      full_reg <= 1'b1;
    end else if (full_reg && ({1'b0, ot_cur} < full_off)) begin
      full_reg <= 1'b0; // [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !full_reg) begin
      ot_ms_reg <= 14'h0000; // [R19]
    end else if (tick && (ot_ms_reg < ot_limit)) begin
      ot_ms_reg <= ot_ms_reg + 14'h0001;
    end
  end

  // trip: latched until software clears it; a new cause beats the clear
  logic uc_trip_ev, ot_trip_ev, trip_next;
  assign uc_trip_ev = uc_done && resp_reg; // [R3]
  assign ot_trip_ev = ot_done && fault_sel; // [R12]
  assign trip_next = uc_trip_ev || ot_trip_ev || (trip && !(wr_ctrl && wdata[`CLR_TRIP_BIT]));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trip <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      trip <= trip_next; // [R3] [R12]
      stop_req <= trip_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_code <= load_current_protection_monitor_pkg::FAULT_NONE;
    end else if (!trip && uc_trip_ev) begin
      fault_code <= load_current_protection_monitor_pkg::FAULT_UNDERCURRENT; // [R3]
    end else if (!trip && ot_trip_ev) begin
      fault_code <= load_current_protection_monitor_pkg::FAULT_OVERTORQUE; // [R12]
    end else if (!trip_next) begin
      fault_code <= load_current_protection_monitor_pkg::FAULT_NONE;
    end
  end

  // relay outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uc_alarm <= 1'b0;
      ot_alarm <= 1'b0;
      ot_timed <= 1'b0;
    end else begin
      uc_alarm <= uc_done && !resp_reg; // [R2]
      ot_alarm <= near_reg; // [R8] [R9]
      ot_timed <= ot_done; // [R10]
    end
  end

  // overvoltage limit actions
  logic ov_at_level;
  assign ov_at_level = {1'b0, bus_voltage} >= scale(ovl_lvl_reg, `FULL_SCALE); // [R18]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ov_extend_decel <= 1'b0;
      ov_overexcite <= 1'b0;
    end else begin
      ov_extend_decel <= (ov_mode_reg == load_current_protection_monitor_pkg::OV_AVOID) && ov_at_level; // [R16]
      case (ov_mode_reg)
        load_current_protection_monitor_pkg::OV_EXCITE_LEVEL: ov_overexcite <= ov_at_level; // [R17]
        load_current_protection_monitor_pkg::OV_EXCITE_DECEL: ov_overexcite <= decelerating; // [R17]
        default: ov_overexcite <= 1'b0;
      endcase
    end
  end

  // interrupt: uc alarm, ot alarm, ot timed, trip onsets
  logic [3:0] irq_ev, irq_stat_next;
  assign irq_ev = {trip_next && !trip, ot_done && !ot_timed, near_reg && !ot_alarm,
                   uc_done && !resp_reg && !uc_alarm};
  assign irq_stat_next = (irq_stat_reg & ~(wr_istat ? wdata[3:0] : 4'h0)) | irq_ev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= wr_imask ? wdata[3:0] : irq_mask_reg;
      irq <= |(irq_stat_next & (wr_imask ? wdata[3:0] : irq_mask_reg));
    end
  end

  // read port; unmapped addresses and idle cycles read zero
  always_ff @(posedge clk) begin
    if (!rst_n || !rd_en) begin
      rdata <= 32'h0000_0000;
    end else if (addr == `CFG_OFS) begin
      rdata <= {22'h0, ov_mode_reg, 1'b0, ovsel_reg, 3'h0, resp_reg};
    end else if (addr == `UC_OFS) begin
      rdata <= {8'h00, uc_time_reg, 3'h0, uc_hyst_reg, 1'b0, uc_thr_reg};
    end else if (addr == `OT_OFS) begin
      rdata <= {9'h000, ot_time_reg, 1'b0, ot_hyst_reg, ot_lvl_reg};
    end else if (addr == `OVL_OFS) begin
      rdata <= {24'h00_0000, ovl_lvl_reg};
    end else if (addr == `STAT_OFS) begin
      rdata <= {24'h00_0000, fault_code, trip, ot_done, near_reg, full_reg, uc_cond_reg, uc_done};
    end else if (addr == `IRQ_STAT_OFS) begin
      rdata <= {28'h000_0000, irq_stat_reg};
    end else if (addr == `IRQ_MASK_OFS) begin
      rdata <= {28'h000_0000, irq_mask_reg};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_uc_timed;
    uc_done && !wr_cfg;
  endsequence

  property p_uc_alarm_only;
    s_uc_timed and !resp_reg |=>
      uc_alarm && !$rose(fault_code == load_current_protection_monitor_pkg::FAULT_UNDERCURRENT);
  endproperty
  a_uc_alarm_only: assert property (p_uc_alarm_only) else $error("uc alarm missing"); // [R2]

  property p_uc_trip;
    s_uc_timed and resp_reg |=> trip && stop_req;
  endproperty
  a_uc_trip: assert property (p_uc_trip) else $error("uc trip missing"); // [R3]

  property p_alarm_sel_no_trip;
    !fault_sel && !resp_reg && !trip && !wr_cfg |=> !trip;
  endproperty
  a_alarm_sel_no_trip: assert property (p_alarm_sel_no_trip) else $error("trip in alarm mode"); // [R11]

  property p_near_level;
    !near_reg && ({1'b0, ot_cur} >= near_on) |=> near_reg ##1 ot_alarm;
  endproperty
  a_near_level: assert property (p_near_level) else $error("immediate alarm late"); // [R8]

  property p_near_100;
    !near70_sel && !near_reg && ({1'b0, ot_cur} < full_on) |=> !near_reg;
  endproperty
  a_near_100: assert property (p_near_100) else $error("alarm below level"); // [R9]

  property p_timed;
    full_reg && (ot_ms_reg >= ot_limit) |=> ot_timed;
  endproperty
  a_timed: assert property (p_timed) else $error("timed relay missing"); // [R10]

  property p_ot_trip;
    ot_done && fault_sel |=> trip ##0 stop_req;
  endproperty
  a_ot_trip: assert property (p_ot_trip) else $error("overtorque trip missing"); // [R12]

  property p_timer_restart;
    !full_reg |=> ot_ms_reg == 14'h0000;
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted"); // [R19]

  property p_ov_off;
    ov_mode_reg == load_current_protection_monitor_pkg::OV_OFF && !wr_cfg |=> !ov_overexcite && !ov_extend_decel;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("ov action in off mode"); // [R17]

endmodule : load_current_protection_monitor

/* testbench/drive_stop_model.sv */
`timescale 1ns/1ps
module drive_stop_model (
  // drive side
  input wire logic stop_req,
  input wire logic decel_cmd,
  output logic decelerating
);
  // a tripped drive coasts, so it never reports a controlled deceleration
  always_comb begin
    decelerating = decel_cmd & ~stop_req;
  end
endmodule : drive_stop_model

/* testbench/load_current_protection_monitor_tb.sv */
`timescale 1ns/1ps
`include "load_current_protection_monitor_regs.svh"
module load_current_protection_monitor_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic [11:0] torque_current = 12'h000;
  logic [11:0] output_current = 12'h000;
  logic [11:0] bus_voltage = 12'h000;
  logic decel_cmd = 1'b0;
  logic decelerating;
  logic uc_alarm, ot_alarm, ot_timed, trip, stop_req, ov_extend_decel, ov_overexcite, irq;
  load_current_protection_monitor_pkg::fault_t fault_code;
  int n_errors = 0;
  int check_count = 0;
  int seed = 32'h26d9_64e9;
  logic [31:0] d;

  always #20 clk = ~clk;

  // short tick keeps the timed paths to a few thousand cycles
  load_current_protection_monitor #(.TICK_CYCLES(4)) u_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .torque_current(torque_current), .output_current(output_current),
    .bus_voltage(bus_voltage), .decelerating(decelerating), .uc_alarm(uc_alarm),
    .ot_alarm(ot_alarm), .ot_timed(ot_timed), .trip(trip), .stop_req(stop_req),
    .fault_code(fault_code), .ov_extend_decel(ov_extend_decel), .ov_overexcite(ov_overexcite),
    .irq(irq)
  );

  drive_stop_model u_drive (.stop_req(stop_req), .decel_cmd(decel_cmd), .decelerating(decelerating));

  function automatic logic near_exp(input int sel, input int cur, input int lvl);
    return (sel == 2 || sel == 5) ? (cur >= lvl * 10) : (cur >= lvl * 7);
  endfunction : near_exp

  function automatic logic trip_exp(input int sel);
    return sel == 1 || sel == 4;
  endfunction : trip_exp

  task automatic wrap_up;
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic drv(input int t, input int o);
    @(posedge clk);
    torque_current <= 12'(t);
    output_current <= 12'(o);
  endtask : drv

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    int rnd;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk("outputs", 32'h0, {uc_alarm, ot_alarm, ot_timed, trip, stop_req, irq});
    rd(`CFG_OFS); chk("cfg", 32'h0000_0200, d);
    rd(`UC_OFS); chk("uc", 32'h0000_0A00, d);
    rd(`OT_OFS); chk("ot", 32'h0005_0A82, d);
    rd(`OVL_OFS); chk("ovl", 32'h0000_0082, d);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20); chk("unmapped", 32'h0, d);
    // every selection at the 70 % and the full level, time zero
    wr(`OT_OFS, 32'h0000_0A64);
    for (int s = 0; s < 6; s++) begin
      wr(`CFG_OFS, 32'h0000_0100 | (s << 4));
      rnd = $unsigned($random(seed)) % 600;
      drv(s < 3 ? 700 : rnd, s < 3 ? rnd : 700);
      cyc(4);
      chk("ot_alarm", near_exp(s, 700, 100), ot_alarm);
      chk("ot_timed", 32'h0, ot_timed);
      drv(s < 3 ? 1000 : rnd, s < 3 ? rnd : 1000);
      cyc(4);
      chk("ot_alarm", 32'h1, ot_alarm);
      chk("ot_timed", 32'h1, ot_timed);
      chk("trip", trip_exp(s), trip);
      chk("stop_req", trip_exp(s), stop_req);
      chk("fault", trip_exp(s) ? 32'h2 : 32'h0, fault_code);
      drv(0, 0);
      cyc(4);
      wr(`CTRL_OFS, 32'h0000_0001);
      cyc(2);
      chk("trip", 32'h0, trip);
    end
    // 100 ms qualification, hysteresis hold and timer restart
    wr(`OT_OFS, 32'h0001_0A64);
    wr(`CFG_OFS, 32'h0000_0100);
    drv(1000, 0);
    cyc(350); chk("ot_timed", 32'h0, ot_timed);
    cyc(100); chk("ot_timed", 32'h1, ot_timed);
    drv(950, 0);
    cyc(10); chk("ot_timed", 32'h1, ot_timed);
    drv(850, 0);
    cyc(5); chk("ot_timed", 32'h0, ot_timed);
    drv(1000, 0);
    cyc(350); chk("ot_timed", 32'h0, ot_timed);
    drv(0, 600);
    // undercurrent 50 %, hysteresis 10 %, 1 s
    wr(`UC_OFS, 32'h0001_0A32);
    drv(0, 400);
    cyc(3900); chk("uc_alarm", 32'h0, uc_alarm);
    cyc(200); chk("uc_alarm", 32'h1, uc_alarm);
    chk("trip", 32'h0, trip);
    drv(0, 550);
    cyc(10); chk("uc_alarm", 32'h1, uc_alarm);
    drv(0, 600);
    cyc(5); chk("uc_alarm", 32'h0, uc_alarm);
    wr(`CFG_OFS, 32'h0000_0101);
    drv(0, 400);
    cyc(4200); chk("trip", 32'h1, trip);
    chk("fault", 32'h1, fault_code);
    chk("stop_req", 32'h1, stop_req);
    drv(0, 600);
    wr(`CTRL_OFS, 32'h0000_0001);
    wr(`CFG_OFS, 32'h0000_0100);
    // interrupt: masked, enabled, cleared, raised again
    wr(`IRQ_MASK_OFS, 32'h0);
    cyc(2); chk("irq", 32'h0, irq);
    rd(`IRQ_STAT_OFS); chk("irq_stat", 32'h0000_000F, d);
    wr(`IRQ_MASK_OFS, 32'h0000_000F);
    cyc(2); chk("irq", 32'h1, irq);
    wr(`IRQ_STAT_OFS, 32'h0000_000F);
    cyc(2); chk("irq", 32'h0, irq);
    rd(`IRQ_STAT_OFS); chk("irq_stat", 32'h0, d);
    drv(1000, 600);
    cyc(4); chk("irq", 32'h1, irq);
    rd(`IRQ_STAT_OFS); chk("irq_stat", 32'h0000_0002, d);
    drv(0, 600);
    // overvoltage modes at the level and one step under it
    for (int m = 0; m < 4; m++) begin
      wr(`CFG_OFS, m << 8);
      @(posedge clk);
      bus_voltage <= 12'd1300;
      decel_cmd <= 1'b1;
      cyc(3);
      chk("ov_extend", m == 0, ov_extend_decel);
      chk("ov_excite", m >= 2, ov_overexcite);
      @(posedge clk);
      bus_voltage <= 12'd1299;
      cyc(3);
      chk("ov_extend", 32'h0, ov_extend_decel);
      chk("ov_excite", m == 3, ov_overexcite);
    end
    // out-of-range settings saturate; status shows the new low-current condition
    wr(`CFG_OFS, 32'hFFFF_FFFF);
    rd(`CFG_OFS); chk("cfg_sat", 32'h0000_0351, d);
    wr(`UC_OFS, 32'h00FF_00FF);
    rd(`UC_OFS); chk("uc_sat", 32'h00FF_0164, d);
    wr(`OT_OFS, 32'hFFFF_FFFF);
    rd(`OT_OFS); chk("ot_sat", 32'h0064_64FA, d);
    wr(`OVL_OFS, 32'h0000_0000);
    rd(`OVL_OFS); chk("ovl_sat", 32'h0000_0064, d);
    rd(`STAT_OFS); chk("status", 32'h0000_0002, d);
    // full 10.0 s qualification must not finish early
    drv(0, 2600);
    cyc(3500); chk("ot_timed", 32'h0, ot_timed);
    chk("ot_alarm", 32'h1, ot_alarm);
    chk("trip", 32'h0, trip);
    wrap_up();
  end
endmodule : load_current_protection_monitor_tb
